/* inc/cio_consts.svh */
`ifndef CIO_CONSTS_SVH
`define CIO_CONSTS_SVH

// Register byte offsets, port form (one bit per pin)
`define CIO_OFF_OUT_VALUE 8'h00
`define CIO_OFF_PIN_STATE 8'h04
`define CIO_OFF_DM0 8'h08
`define CIO_OFF_DM1 8'h0C
`define CIO_OFF_DM2 8'h10
`define CIO_OFF_BYPASS 8'h14
`define CIO_OFF_BIDIR 8'h18
`define CIO_OFF_INT_RISE 8'h1C
`define CIO_OFF_INT_FALL 8'h20
`define CIO_OFF_INT_STAT 8'h24
`define CIO_OFF_INT_MASK 8'h28
`define CIO_OFF_REGULATED 8'h2C

// Pin form: one word per pin from this base, stride 4
`define CIO_OFF_PIN_BASE 8'h40
`define CIO_PIN_SEL_HI 7
`define CIO_PIN_SEL_LO 5
`define CIO_PIN_SEL_VAL 3'h2

// Pin form field positions
`define CIO_PF_OUT 0
`define CIO_PF_STATE 1
`define CIO_PF_DM_LSB 2
`define CIO_PF_DM_MSB 4
`define CIO_PF_BYP 5
`define CIO_PF_BIDIR 6
`define CIO_PF_RISE 7
`define CIO_PF_FALL 8
`define CIO_PF_W 9

// Reset values
`define CIO_RST_DM 3'h0
`define CIO_RST_BIT 1'h0

`endif

/* inc/cio_pkg.sv */
package cio_pkg;

    // Drive mode codes
    typedef enum logic [2:0] {
        CIO_DM_HIZ_ANALOG = 3'h0,
        CIO_DM_HIZ_DIGITAL = 3'h1,
        CIO_DM_RES_UP = 3'h2,
        CIO_DM_RES_DOWN = 3'h3,
        CIO_DM_OD_LOW = 3'h4,
        CIO_DM_OD_HIGH = 3'h5,
        CIO_DM_STRONG = 3'h6,
        CIO_DM_RES_BOTH = 3'h7
    } cio_drive_e;

    // AXI response codes
    typedef enum logic [1:0] {
        CIO_RESP_OKAY = 2'h0,
        CIO_RESP_SLVERR = 2'h2
    } cio_resp_e;

endpackage

/* hdl/cio_pin.sv */
`timescale 1ns/100ps
module cio_pin
    import cio_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Configuration
    input wire cio_pkg::cio_drive_e drive_mode_code,
    input wire logic out_value,
    input wire logic bypass_sel,
    input wire logic bypass_value,
    input wire logic bidir_en,
    input wire logic bidir_oe,
    input wire logic regulated,
    input wire logic bus_pin,
    input wire logic rise_en,
    input wire logic fall_en,
    // Pad
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pull_up,
    output logic pull_dn,
    // Input side
    output logic level,
    output logic event_pulse
);
    import cio_pkg::*;

    logic s1_q, s2_q, s3_q, lvl_q, ev_q;
    logic out_q, oe_q, pu_q, pd_q;
    logic buf_en, lvl_d, val;
    cio_drive_e m_bidir, m_bus, m_eff;

    // Analog high impedance switches the input buffer off
    assign buf_en = (drive_mode_code != CIO_DM_HIZ_ANALOG);
    // Level moves only when the second and third stages agree
    assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    assign level = lvl_q & buf_en;
    assign event_pulse = ev_q;

    // Routed enable drops the pin to digital high impedance
    assign m_bidir = (bidir_en && !bidir_oe) ? CIO_DM_HIZ_DIGITAL : drive_mode_code;
    // Bus pins only know input or push-pull
    assign m_bus = (bus_pin && m_bidir > CIO_DM_HIZ_DIGITAL) ? CIO_DM_STRONG : m_bidir;
    // Regulated special pins have no resistive modes; fall back to input only
    assign m_eff = (regulated && (m_bus == CIO_DM_RES_UP || m_bus == CIO_DM_RES_DOWN
                   || m_bus == CIO_DM_RES_BOTH)) ? CIO_DM_HIZ_DIGITAL : m_bus;
    assign val = bypass_sel ? bypass_value : out_value;

    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign pull_up = pu_q;
    assign pull_dn = pd_q;

    // Input synchroniser and edge detector
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
            lvl_q <= 1'h0;
            ev_q <= 1'h0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            ev_q <= buf_en && ((rise_en && lvl_d && !lvl_q)
                  || (fall_en && !lvl_d && lvl_q));
        end
    end

    // Drive table, registered so the pad sees clean levels
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_q <= 1'h0;
            oe_q <= 1'h0;
            pu_q <= 1'h0;
            pd_q <= 1'h0;
        end
        else
        begin
            out_q <= val;
            oe_q <= 1'h0;
            pu_q <= 1'h0;
            pd_q <= 1'h0;
            case (m_eff)
                CIO_DM_RES_UP:
                begin
                    oe_q <= !val;
                    pu_q <= val;
                end
                CIO_DM_RES_DOWN:
                begin
                    oe_q <= val;
                    pd_q <= !val;
                end
                CIO_DM_OD_LOW: oe_q <= !val;
                CIO_DM_OD_HIGH: oe_q <= val;
                CIO_DM_STRONG: oe_q <= 1'h1;
                CIO_DM_RES_BOTH:
                begin
                    pu_q <= val;
                    pd_q <= !val;
                end
                default: oe_q <= 1'h0;
            endcase
        end
    end
endmodule

/* hdl/cio_port.sv */
`timescale 1ns/100ps
`include "cio_consts.svh"
module cio_port #(
    parameter int NPINS = 8,
    parameter logic [7:0] SPECIAL_MASK = 8'h00,
    parameter logic [7:0] BUS_MASK = 8'h00
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output cio_pkg::cio_resp_e s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output cio_pkg::cio_resp_e s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_pull_up,
    output logic [NPINS-1:0] pin_pull_dn,
    // Routing fabric
    input wire logic [NPINS-1:0] fabric_out,
    input wire logic [NPINS-1:0] fabric_oe,
    output logic [NPINS-1:0] fabric_in,
    // Port interrupt request
    output logic irq
);
    import cio_pkg::*;

    localparam int PAD = 32 - NPINS;
    localparam int PFPAD = 32 - `CIO_PF_W;

    logic aw_have_q, w_have_q, bvalid_q, rvalid_q, irq_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q;
    logic [3:0] w_strb_q;
    cio_resp_e bresp_q, rresp_q;
    logic [NPINS-1:0] out_q, dm0_q, dm1_q, dm2_q, byp_q, bie_q;
    logic [NPINS-1:0] rise_q, fall_q, stat_q, mask_q, regl_q;
    logic [NPINS-1:0] level, events, stat_clr, stat_d, port_new;
    logic [`CIO_PF_W-1:0] pin_word [NPINS];
    logic [`CIO_PF_W-1:0] pw_new;
    logic [31:0] wmask, rd_word;
    logic [2:0] widx, ridx;
    logic do_wr, ar_fire, wr_hit, rd_hit, wr_pin, rd_pin;
    logic wr_out, wr_dm0, wr_dm1, wr_dm2, wr_byp, wr_bie;
    logic wr_rise, wr_fall, wr_stat, wr_mask, wr_regl;
    logic rd_stat;

    // AXI handshakes; address and data are taken in either order
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_wr = aw_have_q && w_have_q && !bvalid_q;
    assign ar_fire = s_axi_arvalid && !rvalid_q;

    // Byte strobes widened to a bit mask
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign port_new = w_data_q[NPINS-1:0];

    // Write decode
    assign widx = aw_addr_q[4:2];
    assign wr_pin = do_wr && aw_addr_q[`CIO_PIN_SEL_HI:`CIO_PIN_SEL_LO] == `CIO_PIN_SEL_VAL
                    && aw_addr_q[1:0] == 2'h0 && int'(widx) < NPINS;
    assign wr_out = do_wr && aw_addr_q == `CIO_OFF_OUT_VALUE;
    assign wr_dm0 = do_wr && aw_addr_q == `CIO_OFF_DM0;
    assign wr_dm1 = do_wr && aw_addr_q == `CIO_OFF_DM1;
    assign wr_dm2 = do_wr && aw_addr_q == `CIO_OFF_DM2;
    assign wr_byp = do_wr && aw_addr_q == `CIO_OFF_BYPASS;
    assign wr_bie = do_wr && aw_addr_q == `CIO_OFF_BIDIR;
    assign wr_rise = do_wr && aw_addr_q == `CIO_OFF_INT_RISE;
    assign wr_fall = do_wr && aw_addr_q == `CIO_OFF_INT_FALL;
    assign wr_stat = do_wr && aw_addr_q == `CIO_OFF_INT_STAT;
    assign wr_mask = do_wr && aw_addr_q == `CIO_OFF_INT_MASK;
    assign wr_regl = do_wr && aw_addr_q == `CIO_OFF_REGULATED;
    // Pin state is read only, so a write to it is an error
    assign wr_hit = wr_pin || wr_out || wr_dm0 || wr_dm1 || wr_dm2 || wr_byp || wr_bie
                    || wr_rise || wr_fall || wr_stat || wr_mask || wr_regl;
    // Pin form write merges strobed bytes into the pin's current word
    assign pw_new = (pin_word[widx] & ~wmask[`CIO_PF_W-1:0])
                    | (w_data_q[`CIO_PF_W-1:0] & wmask[`CIO_PF_W-1:0]);

    // Read decode
    assign ridx = s_axi_araddr[4:2];
    assign rd_pin = s_axi_araddr[`CIO_PIN_SEL_HI:`CIO_PIN_SEL_LO] == `CIO_PIN_SEL_VAL
                    && s_axi_araddr[1:0] == 2'h0 && int'(ridx) < NPINS;
    assign rd_stat = s_axi_araddr == `CIO_OFF_INT_STAT;
    // State is read from the pins, never from the output register
    assign rd_word =
        rd_pin ? {{PFPAD{1'b0}}, pin_word[ridx]} :
        (s_axi_araddr == `CIO_OFF_OUT_VALUE) ? {{PAD{1'b0}}, out_q} :
        (s_axi_araddr == `CIO_OFF_PIN_STATE) ? {{PAD{1'b0}}, level} :
        (s_axi_araddr == `CIO_OFF_DM0) ? {{PAD{1'b0}}, dm0_q} :
        (s_axi_araddr == `CIO_OFF_DM1) ? {{PAD{1'b0}}, dm1_q} :
        (s_axi_araddr == `CIO_OFF_DM2) ? {{PAD{1'b0}}, dm2_q} :
        (s_axi_araddr == `CIO_OFF_BYPASS) ? {{PAD{1'b0}}, byp_q} :
        (s_axi_araddr == `CIO_OFF_BIDIR) ? {{PAD{1'b0}}, bie_q} :
        (s_axi_araddr == `CIO_OFF_INT_RISE) ? {{PAD{1'b0}}, rise_q} :
        (s_axi_araddr == `CIO_OFF_INT_FALL) ? {{PAD{1'b0}}, fall_q} :
        rd_stat ? {{PAD{1'b0}}, stat_q} :
        (s_axi_araddr == `CIO_OFF_INT_MASK) ? {{PAD{1'b0}}, mask_q} :
        (s_axi_araddr == `CIO_OFF_REGULATED) ? {{PAD{1'b0}}, regl_q} :
        32'h0000_0000;
    // Port form words sit back to back from the first offset to the last
    assign rd_hit = rd_pin || (s_axi_araddr <= `CIO_OFF_REGULATED && s_axi_araddr[1:0] == 2'h0);

    // Status: read clears, write one clears, a new event always wins
    assign stat_clr = ((ar_fire && rd_stat) ? {NPINS{1'b1}} : {NPINS{1'b0}})
                      | (wr_stat ? (port_new & wmask[NPINS-1:0]) : {NPINS{1'b0}});
    assign stat_d = (stat_q & ~stat_clr) | events;
    assign irq = irq_q;

    // Write channel
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_have_q <= 1'h0;
            w_have_q <= 1'h0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'h0;
            bresp_q <= CIO_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_have_q)
            begin
                aw_have_q <= 1'h1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (do_wr)
                aw_have_q <= 1'h0;
            if (s_axi_wvalid && !w_have_q)
            begin
                w_have_q <= 1'h1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (do_wr)
                w_have_q <= 1'h0;
            if (do_wr)
            begin
                bvalid_q <= 1'h1;
                bresp_q <= wr_hit ? CIO_RESP_OKAY : CIO_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'h0;
        end
    end

    // Read channel
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rvalid_q <= 1'h0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= CIO_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_q <= 1'h1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? CIO_RESP_OKAY : CIO_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'h0;
    end

    // Output data and drive mode planes, either register form
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_q <= {NPINS{`CIO_RST_BIT}};
            dm0_q <= {NPINS{`CIO_RST_BIT}};
            dm1_q <= {NPINS{`CIO_RST_BIT}};
            dm2_q <= {NPINS{`CIO_RST_BIT}};
        end
        else if (wr_pin)
        begin
            out_q[widx] <= pw_new[`CIO_PF_OUT];
            dm0_q[widx] <= pw_new[`CIO_PF_DM_LSB];
            dm1_q[widx] <= pw_new[`CIO_PF_DM_LSB + 1];
            dm2_q[widx] <= pw_new[`CIO_PF_DM_MSB];
        end
        else
        begin
            out_q <= wr_out ? (out_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : out_q;
            dm0_q <= wr_dm0 ? (dm0_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : dm0_q;
            dm1_q <= wr_dm1 ? (dm1_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : dm1_q;
            dm2_q <= wr_dm2 ? (dm2_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : dm2_q;
        end
    end

    // Bypass, bidirectional and edge selection, either register form
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            byp_q <= {NPINS{`CIO_RST_BIT}};
            bie_q <= {NPINS{`CIO_RST_BIT}};
            rise_q <= {NPINS{`CIO_RST_BIT}};
            fall_q <= {NPINS{`CIO_RST_BIT}};
        end
        else if (wr_pin)
        begin
            byp_q[widx] <= pw_new[`CIO_PF_BYP];
            bie_q[widx] <= pw_new[`CIO_PF_BIDIR];
            rise_q[widx] <= pw_new[`CIO_PF_RISE];
            fall_q[widx] <= pw_new[`CIO_PF_FALL];
        end
        else
        begin
            byp_q <= wr_byp ? (byp_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : byp_q;
            bie_q <= wr_bie ? (bie_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : bie_q;
            rise_q <= wr_rise ? (rise_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : rise_q;
            fall_q <= wr_fall ? (fall_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]) : fall_q;
        end
    end

    // Interrupt status, mask and regulated-level selection
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stat_q <= {NPINS{`CIO_RST_BIT}};
            mask_q <= {NPINS{`CIO_RST_BIT}};
            regl_q <= {NPINS{`CIO_RST_BIT}};
            irq_q <= 1'h0;
        end
        else
        begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
            if (wr_mask)
                mask_q <= (mask_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]);
            // Only special pins can select the regulated level
            if (wr_regl)
                regl_q <= ((regl_q & ~wmask[NPINS-1:0]) | (port_new & wmask[NPINS-1:0]))
                          & SPECIAL_MASK[NPINS-1:0];
        end
    end

    // One pin slice per pin; fabric sees the gated input level
    assign fabric_in = level;
    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
        assign pin_word[i] = {fall_q[i], rise_q[i], bie_q[i], byp_q[i],
                              dm2_q[i], dm1_q[i], dm0_q[i], level[i], out_q[i]};
        cio_pin u_pin (
            .clock(clock),
            .sys_rst(sys_rst),
            .drive_mode_code(cio_drive_e'({dm2_q[i], dm1_q[i], dm0_q[i]})),
            .out_value(out_q[i]),
            .bypass_sel(byp_q[i]),
            .bypass_value(fabric_out[i]),
            .bidir_en(bie_q[i]),
            .bidir_oe(fabric_oe[i]),
            .regulated(regl_q[i]),
            .bus_pin(BUS_MASK[i]),
            .rise_en(rise_q[i]),
            .fall_en(fall_q[i]),
            .pin_in(pin_in[i]),
            .pin_out(pin_out[i]),
            .pin_oe(pin_oe[i]),
            .pull_up(pin_pull_up[i]),
            .pull_dn(pin_pull_dn[i]),
            .level(level[i]),
            .event_pulse(events[i])
        );
    end
endmodule

/* dv/cio_port_properties.sv */
`timescale 1ns/100ps
module cio_port_properties
    import cio_pkg::*;
#(
    parameter int NPINS = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire cio_pkg::cio_resp_e s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads, fabric and request
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_pull_up,
    input wire logic [NPINS-1:0] pin_pull_dn,
    input wire logic [NPINS-1:0] fabric_in,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic cfg_seen_q;
    logic cfg_seen_d;

    // A write counts as landed from its response on
    assign cfg_seen_d = cfg_seen_q | s_axi_bvalid;

    // Any write since the last reset
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            cfg_seen_q <= 1'b0;
        else
            cfg_seen_q <= cfg_seen_d;

    AST_RESET_QUIET: assert property (!cfg_seen_d |-> pin_oe == '0 && pin_pull_up == '0
        && pin_pull_dn == '0) else $error("pad driven before setup");
    AST_NO_ANALOG_INPUT: assert property (!cfg_seen_d |-> fabric_in == '0)
        else $error("input from analog pin");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    AST_WR_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer kept");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data kept");
    AST_IRQ_HOLD: assert property (irq && s_axi_awready && !s_axi_arvalid && !s_axi_rvalid
        && !s_axi_bvalid && !$past(s_axi_bvalid) |=> irq) else $error("request dropped");
    AST_IRQ_CLEAR: assert property ($fell(irq) |-> s_axi_rvalid || s_axi_bvalid
        || $past(s_axi_bvalid)) else $error("request cleared without access");

    // Main scenarios
    COV_IRQ_RISE: cover property ($rose(irq));
    COV_IRQ_FALL: cover property ($fell(irq));
    COV_WR_ERR: cover property (s_axi_bvalid && s_axi_bresp == CIO_RESP_SLVERR);
endmodule

/* dv/cio_pad_model.sv */
`timescale 1ns/100ps
module cio_pad_model #(
    parameter int NPINS = 8
) (
    // Clock
    input wire logic clock,
    // Port pad drive
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pull_up,
    input wire logic [NPINS-1:0] pull_dn,
    // Board driver
    input wire logic [NPINS-1:0] ext_val,
    input wire logic [NPINS-1:0] ext_en,
    // Level seen by the port
    output logic [NPINS-1:0] pin_in
);
    logic [NPINS-1:0] float_q = '0;

    // Floating pad toggles, so it never looks driven
    always_ff @(posedge clock)
        float_q <= ~float_q;

    // Port driver wins, then the board, then the 5K pulls
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up | (~pull_dn & float_q)));
endmodule

/* dv/cio_port_bench.sv */
`timescale 1ns/100ps
module cio_port_bench;
    import cio_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; cio_resp_e r; logic [31:0] q;} cio_row_s;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    cio_resp_e s_axi_bresp, s_axi_rresp;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_dn, fabric_in;
    logic [7:0] fabric_out = '0, fabric_oe = '0, ext_val = '0, ext_en = '0;
    int mismatches = 0, checks_done = 0;
    localparam cio_resp_e OK = CIO_RESP_OKAY, ER = CIO_RESP_SLVERR;
    cio_row_s rows [16] = '{
        '{1'b0, 8'h00, 32'h0, OK, 32'h0}, '{1'b0, 8'h08, 32'h0, OK, 32'h0},
        '{1'b0, 8'h24, 32'h0, OK, 32'h0}, '{1'b1, 8'h00, 32'hA5, OK, 32'h0},
        '{1'b0, 8'h00, 32'h0, OK, 32'hA5}, '{1'b1, 8'h04, 32'hFF, ER, 32'h0},
        '{1'b0, 8'h30, 32'h0, ER, 32'h0}, '{1'b1, 8'h60, 32'h1, ER, 32'h0},
        '{1'b1, 8'h44, 32'h18, OK, 32'h0}, '{1'b0, 8'h0C, 32'h0, OK, 32'h2},
        '{1'b0, 8'h10, 32'h0, OK, 32'h2}, '{1'b0, 8'h08, 32'h0, OK, 32'h0},
        '{1'b0, 8'h00, 32'h0, OK, 32'hA5}, '{1'b1, 8'h2C, 32'hFF, OK, 32'h0},
        '{1'b0, 8'h2C, 32'h0, OK, 32'h80}, '{1'b1, 8'h2C, 32'h0, OK, 32'h0}};

    cio_port #(.NPINS(8), .SPECIAL_MASK(8'h80), .BUS_MASK(8'h40)) u_dut (
        .clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_dn,
        .fabric_out, .fabric_oe, .fabric_in, .irq);

    cio_pad_model #(.NPINS(8)) u_pad (.clock, .pin_out, .pin_oe, .pull_up(pin_pull_up),
        .pull_dn(pin_pull_dn), .ext_val, .ext_en, .pin_in);

    // Free-running system clock
    always #12.5 clock = ~clock;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input cio_resp_e got, input cio_resp_e exp);
        chk_data({30'h0, got}, {30'h0, exp});
    endtask

    // Called just after a rising edge; ready lines stay high, answers taken at the edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output cio_resp_e r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] q, output cio_resp_e r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        q = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        cio_resp_e r;
        axi_wr(a, d, r);
        chk_resp(r, CIO_RESP_OKAY);
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
        cio_resp_e r;
        logic [31:0] q;
        axi_rd(a, q, r);
        chk_resp(r, CIO_RESP_OKAY);
        chk_data(q, e);
    endtask

    // Pin form word: fall, rise, bidir, bypass, code, state, out
    task automatic set_pin(input int p, input logic [8:0] v);
        wr_ok(8'h40 + 8'(4 * p), {23'h0, v});
    endtask

    task automatic pin_chk(input int p, input logic [3:0] e);
        repeat (3) @(posedge clock);
        chk_data({28'h0, pin_oe[p], pin_out[p] & pin_oe[p], pin_pull_up[p], pin_pull_dn[p]},
            {28'h0, e});
    endtask

    // Pad drive, value, pull up, pull down for each code and data value
    function automatic logic [3:0] drv_exp(input logic [2:0] m, input logic d);
        case (m)
            3'h2: drv_exp = d ? 4'h2 : 4'h8;
            3'h3: drv_exp = d ? 4'hC : 4'h1;
            3'h4: drv_exp = d ? 4'h0 : 4'h8;
            3'h5: drv_exp = d ? 4'hC : 4'h0;
            3'h6: drv_exp = d ? 4'hC : 4'h8;
            3'h7: drv_exp = d ? 4'h2 : 4'h1;
            default: drv_exp = 4'h0;
        endcase
    endfunction

    task automatic wait_irq(input logic e);
        repeat (8) @(posedge clock);
        chk_data({31'h0, irq}, {31'h0, e});
    endtask

    // Watchdog sized well above the whole sequence
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        cio_resp_e r;
        logic [31:0] q;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (rows[i])
        begin
            if (rows[i].wr)
                axi_wr(rows[i].a, rows[i].d, r);
            else
                axi_rd(rows[i].a, q, r);
            chk_resp(r, rows[i].r);
            if (!rows[i].wr)
                chk_data(q, rows[i].q);
        end
        $display("test register walk done");
        for (int m = 0; m < 8; m++)
            for (int d = 0; d < 2; d++)
            begin
                set_pin(0, {4'h0, 3'(m), 1'b0, 1'(d)});
                pin_chk(0, drv_exp(3'(m), 1'(d)));
            end
        $display("test drive modes done");
        set_pin(0, {4'h1, 3'h6, 2'b00});
        fabric_out[0] <= 1'b1;
        pin_chk(0, 4'hC);
        fabric_out[0] <= 1'b0;
        pin_chk(0, 4'h8);
        set_pin(0, {4'h2, 3'h6, 2'b01});
        pin_chk(0, 4'h0);
        fabric_oe[0] <= 1'b1;
        pin_chk(0, 4'hC);
        wr_ok(8'h2C, 32'h80);
        set_pin(7, {4'h0, 3'h7, 2'b01});
        pin_chk(7, 4'h0);
        set_pin(6, {4'h0, 3'h2, 2'b01});
        pin_chk(6, 4'hC);
        $display("test bypass bidir special done");
        ext_en[1] <= 1'b1;
        ext_val[1] <= 1'b1;
        set_pin(1, 9'h000);
        wait_irq(1'b0);
        chk_data({31'h0, fabric_in[1]}, 32'h0);
        rd_exp(8'h44, 32'h0);
        set_pin(1, {4'h0, 3'h1, 2'b00});
        wait_irq(1'b0);
        chk_data({31'h0, fabric_in[1]}, 32'h1);
        rd_exp(8'h44, 32'h6);
        $display("test input path done");
        wr_ok(8'h28, 32'h2);
        for (int k = 0; k < 4; k++)
        begin
            set_pin(1, {1'(k >> 1), 1'(k), 2'b00, 3'h1, 2'b00});
            for (int e = 0; e < 2; e++)
            begin
                ext_val[1] <= 1'(e);
                wait_irq(e ? 1'(k) : 1'(k >> 1));
                rd_exp(8'h24, (e ? 1'(k) : 1'(k >> 1)) ? 32'h2 : 32'h0);
                wait_irq(1'b0);
            end
        end
        wr_ok(8'h28, 32'h0);
        ext_val[1] <= 1'b0;
        wait_irq(1'b0);
        wr_ok(8'h28, 32'h2);
        wait_irq(1'b1);
        wr_ok(8'h24, 32'h2);
        wait_irq(1'b0);
        rd_exp(8'h24, 32'h0);
        $display("test interrupts done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        pin_chk(0, 4'h0);
        rd_exp(8'h08, 32'h0);
        $display("test second reset done");
        print_verdict();
    end
endmodule

bind cio_port cio_port_properties #(.NPINS(NPINS)) u_props (.clock, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pin_oe, .pin_pull_up,
    .pin_pull_dn, .fabric_in, .irq);
